//--- rtl/ttc_pkg.sv
package ttc_pkg;
	// ----------------------------------------
	// clocks
	// ----------------------------------------
	localparam int CLK_HZ = 40000000;
	localparam int SLOW_HZ = 32768;
	localparam int FAST_HZ_4M = 4000000;
	localparam int FAST_HZ_2M = 2000000;
	localparam int FAST_HZ_500K = 500000;
	localparam int DIV_W = 16;
	localparam int SLOW_TOP_TAP = 13;
	localparam int SLOW_FIRST_TAP = 11;
	localparam int FAST_TOP_TAP01 = 6;
	localparam int FAST_TOP_TAP2 = 8;

	// ----------------------------------------
	// register indexes (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [5:0] IDX_DATA0 = 6'h00;
	localparam logic [5:0] IDX_CTL0 = 6'h01;
	localparam logic [5:0] IDX_EN0 = 6'h02;
	localparam logic [5:0] IDX_DATA1 = 6'h04;
	localparam logic [5:0] IDX_CTL1 = 6'h05;
	localparam logic [5:0] IDX_EN1 = 6'h06;
	localparam logic [5:0] IDX_DATA2 = 6'h08;
	localparam logic [5:0] IDX_CTL2 = 6'h09;
	localparam logic [5:0] IDX_EN2 = 6'h0A;
	localparam logic [5:0] IDX_STAT = 6'h0C;
	localparam logic [5:0] IDX_MASK = 6'h0D;

	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int RELOAD_BIT = 4;
	localparam int EN_BIT = 0;
	localparam logic [7:0] CTL_RST = 8'h1E;
	localparam logic [7:0] CTL_MASK0 = 8'hDF;
	localparam logic [7:0] CTL_MASK12 = 8'h1F;
	localparam logic [3:0] SRC_FAST_FULL = 4'hF;
	localparam logic [3:0] IRQ_RST = 4'h0;

	typedef enum logic [1:0] {
		TTC_STOP_OFF,
		TTC_STOP_T2UF,
		TTC_STOP_OSC,
		TTC_STOP_T2CLK
	} ttc_stop_t;
endpackage

//--- rtl/ttc_timers.sv
// Overview of operation
// - Slow taps divide the 32.768 kHz slow clock, fast taps divide the 4/2/0.5 MHz fast clock.
// - Timer0 source: 000x pin, 001x slow 13, 0100-0111 slow 11/9/7/5, 1000-1110 fast 6..0, 1111 fast.
// - Timer1 uses the same codes but 000x takes timer0 counter bit 7, cascading the two.
// - Timer2 000x takes timer1 bit 7, slow codes as timer0, 1000-1111 fast taps 8 down to 1.
// - Control bit 4 picks reload when 1 and one-shot when 0, reset value 1.
// - Timer0 stop field: 00 off, 01 timer2 underflow, 10 one pin cycle, 11 one timer2 clock cycle.
// - Enable bit 0 starts a timer counting down and clearing it stops it; reset disables all.
// - Counters count down to zero and in reload mode reload from the latch, period latch plus one.
// - Data register reads the live counter and writes the reload latch.
`timescale 1ns/100ps
`default_nettype none
module ttc_timers
	import ttc_pkg::*;
#(
	parameter int FAST_HZ = FAST_HZ_4M
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic        slow_clock_pin,
	input  wire logic        fast_system_clock,
	input  wire logic        oscillator_input_pin,
	output logic             irq
);
	if (!(FAST_HZ == FAST_HZ_4M || FAST_HZ == FAST_HZ_2M || FAST_HZ == FAST_HZ_500K))
		$error("fast clock option must be 4 MHz, 2 MHz or 500 kHz");
	if (CLK_HZ < 4 * FAST_HZ)
		$error("bus clock too slow to sample the fast clock");

	// ----------------------------------------
	// pin synchronisers and edge detect
	// ----------------------------------------
	logic [2:0]       pin_s1;
	logic [2:0]       pin_s2;
	logic [2:0]       pin_d;
	logic [2:0]       pin_ev;
	logic [DIV_W-1:0] slow_div;
	logic [DIV_W-1:0] fast_div;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
			pin_d <= 3'h0;
		end else if (ce) begin
			pin_s1 <= {oscillator_input_pin, fast_system_clock, slow_clock_pin};
			pin_s2 <= pin_s1;
			pin_d <= pin_s2;
		end
	end
	assign pin_ev = pin_s2 & ~pin_d;

	// slow and fast dividers advance on each rising edge of their clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slow_div <= '0;
			fast_div <= '0;
		end else if (ce) begin
			if (pin_ev[0])
				slow_div <= slow_div + 1'b1;
			if (pin_ev[1])
				fast_div <= fast_div + 1'b1;
		end
	end

	// tap n fires once every 2^(n+1) clock edges
	function automatic logic tap_hit(input logic [DIV_W-1:0] div, input int n);
		logic [DIV_W-1:0] m;
		m = DIV_W'((32'h2 << n) - 1);
		return &(div | ~m);
	endfunction

	// events and dividers come in as arguments so each caller re-evaluates when they move
	function automatic logic src_hit(input logic [3:0] code, input int t, input logic casc,
		input logic sev, input logic fev, input logic [DIV_W-1:0] sdiv,
		input logic [DIV_W-1:0] fdiv);
		if (code[3:1] == 3'h0)
			return casc;
		else if (code[3:1] == 3'h1)
			return sev & tap_hit(sdiv, SLOW_TOP_TAP);
		else if (code[3:2] == 2'h1)
			return sev & tap_hit(sdiv, SLOW_FIRST_TAP - 2 * int'(code[1:0]));
		else if (t == 2)
			return fev & tap_hit(fdiv, FAST_TOP_TAP2 - int'(code[2:0]));
		else if (code == SRC_FAST_FULL)
			return fev;
		else
			return fev & tap_hit(fdiv, FAST_TOP_TAP01 - int'(code[2:0]));
	endfunction

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic [7:0] cnt [0:2];
	logic [7:0] latch [0:2];
	logic [7:0] ctl [0:2];
	logic [2:0] en;
	logic [2:0] done;
	logic       stop0;
	logic [3:0] stat;
	logic [3:0] mask;
	logic       wr_ph;
	logic [5:0] ph_idx;
	logic [7:0] rd_val;

	wire        acc = hsel & hready & htrans[1] & ce;
	wire        in_map = (haddr[31:8] == 24'h0);
	wire  [5:0] a_idx = haddr[7:2];
	wire        wr = wr_ph & ce;
	wire  [7:0] wd = hwdata[7:0];

	assign hreadyout = ce;
	assign hresp = 1'b0;
	assign rd_val = !in_map ? 8'h00 :
		a_idx == IDX_DATA0 ? cnt[0] :
		a_idx == IDX_CTL0 ? ctl[0] :
		a_idx == IDX_EN0 ? {7'h0, en[0]} :
		a_idx == IDX_DATA1 ? cnt[1] :
		a_idx == IDX_CTL1 ? ctl[1] :
		a_idx == IDX_EN1 ? {7'h0, en[1]} :
		a_idx == IDX_DATA2 ? cnt[2] :
		a_idx == IDX_CTL2 ? ctl[2] :
		a_idx == IDX_EN2 ? {7'h0, en[2]} :
		a_idx == IDX_STAT ? {4'h0, stat} :
		a_idx == IDX_MASK ? {4'h0, mask} : 8'h00;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph <= 1'b0;
			ph_idx <= 6'h3F;
			hrdata <= 32'h0;
		end else if (ce) begin
			wr_ph <= acc & hwrite;
			ph_idx <= in_map ? a_idx : 6'h3F;
			if (acc && !hwrite)
				hrdata <= {24'h0, rd_val};
		end
	end

	// ----------------------------------------
	// timer cores
	// ----------------------------------------
	logic [2:0] hit;
	logic [2:0] run;
	logic [2:0] tick;
	logic [2:0] uf;
	logic [2:0] start;
	logic [1:0] b7_d;
	logic [1:0] casc;

	assign casc = b7_d & ~{cnt[1][7], cnt[0][7]};
	assign hit[0] = src_hit(ctl[0][3:0], 0, pin_ev[2], pin_ev[0], pin_ev[1],
		slow_div, fast_div);
	assign hit[1] = src_hit(ctl[1][3:0], 1, casc[0], pin_ev[0], pin_ev[1],
		slow_div, fast_div);
	assign hit[2] = src_hit(ctl[2][3:0], 2, casc[1], pin_ev[0], pin_ev[1],
		slow_div, fast_div);
	assign run = en & ~done & {2'b11, ~stop0};
	assign tick = hit & run;

	for (genvar t = 0; t < 3; t++) begin : g_t
		assign uf[t] = tick[t] & (cnt[t] == 8'h00);
		assign start[t] = wr & (ph_idx == 6'(4 * t + 2)) & wd[EN_BIT] & ~en[t];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			b7_d <= 2'h0;
		end else if (ce) begin
			b7_d <= {cnt[1][7], cnt[0][7]};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int t = 0; t < 3; t++) begin
				cnt[t] <= 8'h00;
				latch[t] <= 8'h00;
				ctl[t] <= CTL_RST;
			end
			en <= 3'h0;
			done <= 3'h0;
		end else if (ce) begin
			for (int t = 0; t < 3; t++) begin
				if (wr && ph_idx == 6'(4 * t))
					latch[t] <= wd;
				if (wr && ph_idx == 6'(4 * t + 1))
					ctl[t] <= wd & (t == 0 ? CTL_MASK0 : CTL_MASK12);
				if (wr && ph_idx == 6'(4 * t + 2))
					en[t] <= wd[EN_BIT];
				if (start[t]) begin
					cnt[t] <= latch[t];
					done[t] <= 1'b0;
				end else if (uf[t]) begin
					if (ctl[t][RELOAD_BIT])
						cnt[t] <= latch[t];
					else
						done[t] <= 1'b1;
				end else if (tick[t]) begin
					cnt[t] <= cnt[t] - 8'h01;
				end
			end
		end
	end

	// ----------------------------------------
	// timer0 stop modes
	// ----------------------------------------
	ttc_stop_t  stop_mode;
	logic [1:0] edge_cnt;
	logic       stop_ev;

	assign stop_mode = ttc_stop_t'(ctl[0][7:6]);
	wire  meas_edge = (stop_mode == TTC_STOP_OSC) ? pin_ev[2] :
		(stop_mode == TTC_STOP_T2CLK) ? hit[2] : 1'b0;
	assign stop_ev = ~stop0 & en[0] & ~start[0] &
		(((stop_mode == TTC_STOP_T2UF) & uf[2]) | (meas_edge & (edge_cnt == 2'h1)));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop0 <= 1'b0;
			edge_cnt <= 2'h0;
		end else if (ce) begin
			if (start[0]) begin
				stop0 <= 1'b0;
				edge_cnt <= 2'h0;
			end else begin
				if (stop_ev)
					stop0 <= 1'b1;
				if (meas_edge && en[0] && !stop0 && edge_cnt != 2'h2)
					edge_cnt <= edge_cnt + 2'h1;
			end
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	wire  [3:0] ev = {stop_ev, uf};
	wire  [3:0] clr = (wr && ph_idx == IDX_STAT) ? wd[3:0] : 4'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat <= IRQ_RST;
			mask <= IRQ_RST;
		end else if (ce) begin
			stat <= (stat & ~clr) | ev;
			if (wr && ph_idx == IDX_MASK)
				mask <= wd[3:0];
		end
	end
	assign irq = |(stat & mask);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	count_down_a: assert property (ce && tick[1] && cnt[1] != 8'h00 && !start[1] |=>
		cnt[1] == $past(cnt[1]) - 8'h01) else $error("timer1 did not decrement");
	reload_a: assert property (ce && uf[0] && ctl[0][RELOAD_BIT] && !start[0] |=>
		cnt[0] == $past(latch[0])) else $error("timer0 did not reload");
	one_shot_a: assert property (ce && uf[2] && !ctl[2][RELOAD_BIT] && !start[2] |=>
		!run[2] && $stable(cnt[2])) else $error("one-shot timer2 kept running");
	idle_hold_a: assert property (ce && !en[1] && !start[1] |=> $stable(cnt[1]))
		else $error("disabled timer1 changed");
	readback_a: assert property (acc && !hwrite && in_map && a_idx == IDX_DATA2 |=>
		hrdata[7:0] == $past(cnt[2])) else $error("data read not live count");
	cascade_a: assert property (ce && ctl[1][3:1] == 3'h0 && run[1] && $fell(cnt[0][7]) |->
		tick[1]) else $error("cascade edge missed");
	stop_t2uf_a: assert property (ce && stop_mode == TTC_STOP_T2UF && en[0] && uf[2] &&
		!start[0] |=> stop0 ##1 !run[0]) else $error("timer0 not stopped");
	full_fast_a: assert property (ce && run[0] && ctl[0][3:0] == SRC_FAST_FULL &&
		pin_ev[1] |-> tick[0]) else $error("undivided fast clock missed");
	t2_tap_a: assert property (ce && run[2] && ctl[2][3:0] == SRC_FAST_FULL && tick[2] |->
		fast_div[0]) else $error("timer2 code 1111 not divided by 4");
	irq_a: assert property (ce && uf[1] && mask[1] |=> irq) else $error("irq not raised");
	cascade2_a: assert property (ce && ctl[2][3:1] == 3'h0 && run[2] && $fell(cnt[1][7]) |->
		tick[2]) else $error("timer2 cascade edge missed");
	stop_flag_a: assert property (ce && stop_ev |=> stat[3] && stop0)
		else $error("timer0 stop not flagged");

	reload_c: cover property (uf[0] && ctl[0][RELOAD_BIT]);
	oneshot_c: cover property (uf[1] && !ctl[1][RELOAD_BIT]);
	stop_c: cover property (stop_ev && stop_mode == TTC_STOP_OSC);
	irq_c: cover property (irq ##1 !irq);
	stop_t2_c: cover property (stop_ev && stop_mode == TTC_STOP_T2UF);
endmodule
`default_nettype wire

//--- tb/triple_timer_clock_select_tb.sv
`timescale 1ns/100ps
`default_nettype none
module triple_timer_clock_select_tb
	import ttc_pkg::*;
;
	logic        hclk;
	logic        hresetn;
	logic        ce;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire         hreadyout;
	wire         hresp;
	wire  [31:0] hrdata;
	logic        slow_clk;
	logic        fast_clk;
	logic        osc_pin;
	wire         irq;
	int          err_count;
	int          checked;
	int          cycles = 0;
	logic [31:0] rv;

	ttc_timers i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .slow_clock_pin(slow_clk),
		.fast_system_clock(fast_clk), .oscillator_input_pin(osc_pin), .irq(irq));

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	initial begin
		fast_clk = 1'b0;
		forever #125 fast_clk = ~fast_clk;
	end
	initial begin
		slow_clk = 1'b0;
		forever #15259 slow_clk = ~slow_clk;
	end

	// ----------------------------------------
	// bus and check tasks
	// ----------------------------------------
	function automatic logic [31:0] a(input logic [5:0] idx);
		return {24'h000000, idx, 2'b00};
	endfunction
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		@(posedge hclk);
		haddr <= a(idx);
		htrans <= 2'h2;
		hwrite <= 1'b1;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask
	task automatic rd(input logic [5:0] idx, output logic [31:0] d);
		@(posedge hclk);
		haddr <= a(idx);
		htrans <= 2'h2;
		hwrite <= 1'b0;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rchk(input string what, input logic [5:0] idx, input logic [7:0] exp);
		rd(idx, rv);
		chk(what, {24'h000000, exp}, rv);
	endtask
	task automatic pin_edges(input int n);
		repeat (n) begin
			@(posedge hclk);
			osc_pin <= 1'b1;
			repeat (4) @(posedge hclk);
			osc_pin <= 1'b0;
			repeat (4) @(posedge hclk);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------
	// timeout
	// ----------------------------------------
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			end_sim();
		end
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		err_count = 0;
		checked = 0;
		hresetn = 1'b0;
		ce = 1'b1;
		hsel = 1'b1;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		osc_pin = 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rchk("ctl reset", 6'(4 * i + 1), CTL_RST);
			rchk("en reset", 6'(4 * i + 2), 8'h00);
			rchk("data reset", 6'(4 * i), 8'h00);
		end
		wr(6'h03, 8'hA5);
		rchk("unmapped", 6'h03, 8'h00);
		$display("reset test done");

		wr(IDX_CTL0, 8'h10);
		wr(IDX_DATA0, 8'h03);
		wr(IDX_MASK, 8'h01);
		wr(IDX_EN0, 8'h01);
		rchk("load", IDX_DATA0, 8'h03);
		pin_edges(2);
		rchk("count", IDX_DATA0, 8'h01);
		pin_edges(2);
		rchk("reload", IDX_DATA0, 8'h03);
		rchk("status", IDX_STAT, 8'h01);
		chk("irq set", 32'h1, {31'h0, irq});
		wr(IDX_STAT, 8'h01);
		rchk("status clr", IDX_STAT, 8'h00);
		chk("irq clr", 32'h0, {31'h0, irq});
		$display("reload test done");

		wr(IDX_EN0, 8'h00);
		wr(IDX_CTL0, 8'h00);
		wr(IDX_DATA0, 8'h02);
		wr(IDX_EN0, 8'h01);
		pin_edges(5);
		rchk("one shot", IDX_DATA0, 8'h00);
		wr(IDX_EN0, 8'h00);
		wr(IDX_EN0, 8'h01);
		rchk("re enable", IDX_DATA0, 8'h02);
		wr(IDX_EN0, 8'h00);
		pin_edges(1);
		rchk("disabled", IDX_DATA0, 8'h02);
		$display("one shot test done");

		wr(IDX_CTL1, 8'h10);
		wr(IDX_DATA1, 8'h05);
		wr(IDX_EN1, 8'h01);
		wr(IDX_CTL0, 8'h10);
		wr(IDX_DATA0, 8'h80);
		wr(IDX_EN0, 8'h01);
		pin_edges(1);
		rchk("t0 cascade", IDX_DATA0, 8'h7F);
		rchk("t1 cascade", IDX_DATA1, 8'h04);
		$display("cascade test done");

		wr(IDX_CTL0, 8'hFF);
		rchk("ctl0 bits", IDX_CTL0, CTL_MASK0);
		wr(IDX_CTL1, 8'hFF);
		rchk("ctl1 bits", IDX_CTL1, CTL_MASK12);
		$display("control test done");

		wr(IDX_EN0, 8'h00);
		wr(IDX_EN1, 8'h00);
		wr(IDX_STAT, 8'h0F);
		wr(IDX_CTL0, 8'h90);
		wr(IDX_DATA0, 8'h10);
		wr(IDX_EN0, 8'h01);
		@(posedge hclk);
		ce <= 1'b0;
		pin_edges(2);
		ce <= 1'b1;
		rchk("frozen", IDX_DATA0, 8'h10);
		pin_edges(4);
		rchk("stop osc", IDX_DATA0, 8'h0E);
		rchk("stop flag", IDX_STAT, 8'h08);
		chk("resp okay", 32'h0, {31'h0, hresp});
		$display("stop test done");

		wr(IDX_CTL1, 8'h0F);
		wr(IDX_DATA1, 8'h80);
		wr(IDX_CTL2, 8'h00);
		wr(IDX_DATA2, 8'h03);
		wr(IDX_EN2, 8'h01);
		wr(IDX_EN1, 8'h01);
		repeat (1500) @(posedge hclk);
		rchk("t2 cascade", IDX_DATA2, 8'h02);
		rchk("t1 one shot", IDX_DATA1, 8'h00);
		$display("timer2 cascade test done");
		end_sim();
	end
endmodule
`default_nettype wire
